// file: hdl/svc_panel_pkg.sv
// Package with constants and carrier types for the service panel and trap monitor.
`default_nettype none
package svc_panel_pkg;
	// ----------------------------------------------------------------
	// Widths and vectors
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 16;
	localparam int WORD_W      = 16;
	localparam int SENSE_W     = 8;
	localparam int SENSE_LSB   = 0;
	localparam int BREAKER_N   = 4;
	localparam int METER_N     = 8;
	localparam int DISP_A_W    = 18;
	localparam int DISP_B_W    = 18;
	localparam int DISP_C_W    = 10;
	localparam int IO_BIT_SVC  = 15;
	localparam logic [ADDR_W-1:0] SVC_VECTOR_ADDR  = 16'h0001;
	localparam logic [ADDR_W-1:0] SVC_RETURN_ADDR  = 16'h000a;
	localparam logic [WORD_W-1:0] WORD_ZERO        = 16'h0000;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SAMPLE_WIN_NS   = 150;
	// Longest time rounds down, but never below one cycle.
	localparam int SAMPLE_WIN_CYC  = (SAMPLE_WIN_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(SAMPLE_WIN_NS / CLK_PERIOD_NS);
	localparam int SAMPLE_CNT_W    = 4;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DISP_CONSOLE,
		DISP_SAMPLED,
		DISP_GATED
	} disp_mode_t;
	typedef enum logic [1:0] {
		IO_NONE,
		IO_SENSE_DEVICE,
		IO_READ
	} io_cmd_t;
	typedef struct packed {
		logic [DISP_A_W-1:0] a;
		logic [DISP_B_W-1:0] b;
		logic [DISP_C_W-1:0] c;
	} disp_lines_t;
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} core_write_t;
endpackage
`default_nettype wire

// file: hdl/trap_monitor.sv
// Portable monitor: three latching display registers with sync, hold and reset.
`default_nettype none
module trap_monitor (
	input  wire logic                             clk,
	input  wire logic                             resetn,
	input  wire svc_panel_pkg::disp_mode_t        mode,
	input  wire svc_panel_pkg::disp_lines_t       lines,
	input  wire logic                             sync,
	input  wire logic                             error,
	input  wire logic                             cycle_end,
	output logic                                  trapped,
	output svc_panel_pkg::disp_lines_t            display
);
	localparam int W = svc_panel_pkg::DISP_A_W + svc_panel_pkg::DISP_B_W
		+ svc_panel_pkg::DISP_C_W;

	svc_panel_pkg::disp_lines_t               disp_ff;
	logic                                     sync_d_ff;
	logic                                     armed_ff;
	logic                                     hold_ff;
	logic [svc_panel_pkg::SAMPLE_CNT_W-1:0]   win_ff;
	logic                                     set_line;
	logic                                     reset_line;
	logic                                     sync_rise;

	assign sync_rise = sync && !sync_d_ff;

	// ----------------------------------------------------------------
	// Set and reset lines
	// ----------------------------------------------------------------
	always_comb begin
		set_line   = 1'b0;
		reset_line = 1'b0;
		case (mode)
			svc_panel_pkg::DISP_CONSOLE: begin
				set_line   = 1'b1;
				reset_line = 1'b1;
			end
			svc_panel_pkg::DISP_SAMPLED: begin
				set_line   = sync_rise || (win_ff != '0);
				reset_line = armed_ff && cycle_end && !hold_ff && !error;
			end
			svc_panel_pkg::DISP_GATED: begin
				set_line   = sync && !hold_ff && !error;
				reset_line = armed_ff && cycle_end && !hold_ff && !error;
			end
			default: begin
				set_line   = 1'b0;
				reset_line = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync_d_ff <= 1'b0;
		end else begin
			sync_d_ff <= sync;
		end
	end

	// Sample window closes a fixed time after the sync rises.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			win_ff <= '0;
		end else if (mode == svc_panel_pkg::DISP_SAMPLED && sync_rise) begin
			win_ff <= svc_panel_pkg::SAMPLE_CNT_W'(svc_panel_pkg::SAMPLE_WIN_CYC - 1);
		end else if (win_ff != '0) begin
			win_ff <= win_ff - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Armed and hold latches
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			armed_ff <= 1'b0;
		end else if (mode == svc_panel_pkg::DISP_CONSOLE) begin
			armed_ff <= 1'b0;
		end else if (sync_rise) begin
			// A new sync in the cycle that ends the last one re-arms.
			armed_ff <= 1'b1;
		end else if (reset_line) begin
			armed_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hold_ff <= 1'b0;
		end else if (mode == svc_panel_pkg::DISP_CONSOLE) begin
			hold_ff <= 1'b0;
		end else if (armed_ff && error) begin
			hold_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Display latches
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			disp_ff <= '0;
		end else if (mode == svc_panel_pkg::DISP_CONSOLE) begin
			disp_ff <= lines;
		end else if (reset_line) begin
			disp_ff <= set_line ? lines : '0;
		end else if (set_line) begin
			disp_ff <= svc_panel_pkg::disp_lines_t'(W'(disp_ff) | W'(lines));
		end
	end

	assign display = disp_ff;
	assign trapped = hold_ff;
endmodule // trap_monitor
`default_nettype wire

// file: hdl/service_panel.sv
// Service panel: storage forcing, service interrupt, sense switches, lamps, meters, monitor.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`default_nettype none
module service_panel (
	input  wire logic                                    clk,
	input  wire logic                                    resetn,
	// Panel switches.
	input  wire logic                                    force_aux_sw,
	input  wire logic                                    int_to_aux_sw,
	input  wire logic                                    svc_button,
	input  wire logic [svc_panel_pkg::SENSE_W-1:0]       sense_sw,
	input  wire logic                                    key_customer,
	input  wire logic [svc_panel_pkg::BREAKER_N-1:0]     breaker_trip,
	input  wire logic [svc_panel_pkg::METER_N-1:0]       unit_in_use,
	// Processor side.
	input  wire logic                                    program_load,
	input  wire logic                                    end_op_t7,
	input  wire logic                                    svc_int_taken,
	input  wire logic                                    svc_level_clear,
	input  wire logic [svc_panel_pkg::WORD_W-1:0]        polled_io_word,
	input  wire logic                                    io_in_service_mode,
	input  wire logic                                    gate_program_switches,
	input  wire logic                                    execute_io_instruction,
	input  wire svc_panel_pkg::io_cmd_t                  io_cmd,
	input  wire logic                                    t3_data_cycle,
	input  wire logic [svc_panel_pkg::ADDR_W-1:0]        instr_addr,
	input  wire logic [svc_panel_pkg::WORD_W-1:0]        chan_bus_in,
	output logic [svc_panel_pkg::WORD_W-1:0]             chan_bus_out,
	output logic                                         aux_storage_select,
	output logic                                         aux_storage_bit,
	output logic                                         main_storage_inhibit,
	output logic                                         svc_level,
	output logic [svc_panel_pkg::ADDR_W-1:0]             svc_vector_addr,
	output logic [svc_panel_pkg::ADDR_W-1:0]             svc_return_addr,
	output logic [svc_panel_pkg::WORD_W-1:0]             operand_buffer,
	output logic [svc_panel_pkg::WORD_W-1:0]             accumulator_load,
	output logic                                         accumulator_we,
	output svc_panel_pkg::core_write_t                   core_write,
	output logic                                         breaker_lamp,
	output logic [svc_panel_pkg::METER_N-1:0]            meter_run,
	// Monitor.
	input  wire svc_panel_pkg::disp_mode_t               mon_mode,
	input  wire svc_panel_pkg::disp_lines_t              mon_lines,
	input  wire logic                                    mon_sync,
	input  wire logic                                    mon_error,
	input  wire logic                                    mon_cycle_end,
	output logic                                         mon_trapped,
	output svc_panel_pkg::disp_lines_t                   mon_display
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	localparam int SW_N = 4 + svc_panel_pkg::SENSE_W;

	logic [SW_N-1:0]                          sw_meta_ff;
	logic [SW_N-1:0]                          sw_sync_ff;
	logic                                     force_aux;
	logic                                     int_to_aux;
	logic                                     button;
	logic                                     customer;
	logic [svc_panel_pkg::SENSE_W-1:0]        sense;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sw_meta_ff <= '0;
			sw_sync_ff <= '0;
		end else begin
			sw_meta_ff <= {force_aux_sw, int_to_aux_sw, svc_button, key_customer, sense_sw};
			sw_sync_ff <= sw_meta_ff;
		end
	end

	assign force_aux  = sw_sync_ff[SW_N-1];
	assign int_to_aux = sw_sync_ff[SW_N-2];
	assign button     = sw_sync_ff[SW_N-3];
	assign customer   = sw_sync_ff[SW_N-4];
	assign sense      = sw_sync_ff[svc_panel_pkg::SENSE_W-1:0];

	// ----------------------------------------------------------------
	// Storage selection
	// ----------------------------------------------------------------
	logic aux_int_ff;

	assign aux_storage_select   = force_aux && program_load;
	assign main_storage_inhibit = force_aux && program_load;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			aux_int_ff <= 1'b0;
		end else if (end_op_t7 && int_to_aux && svc_level) begin
			aux_int_ff <= 1'b1;
		end else if (svc_level_clear) begin
			aux_int_ff <= 1'b0;
		end
	end

	assign aux_storage_bit = aux_storage_select || aux_int_ff;

	// Vector and return address presented with the aux bit selecting the store.
	assign svc_vector_addr = svc_panel_pkg::SVC_VECTOR_ADDR;
	assign svc_return_addr = svc_panel_pkg::SVC_RETURN_ADDR;

	// ----------------------------------------------------------------
	// Service interrupt
	// ----------------------------------------------------------------
	logic shaper_ff;
	logic button_d_ff;
	logic request_ff;
	logic level_ff;
	logic polled_svc;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			button_d_ff <= 1'b0;
			shaper_ff   <= 1'b0;
		end else begin
			button_d_ff <= button;
			shaper_ff   <= button && !button_d_ff;
		end
	end

	// Set wins over the clear when both arrive together.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			request_ff <= 1'b0;
		end else if (shaper_ff) begin
			request_ff <= 1'b1;
		end else if (svc_int_taken) begin
			request_ff <= 1'b0;
		end
	end

	assign polled_svc = io_in_service_mode && polled_io_word[svc_panel_pkg::IO_BIT_SVC];

	always_ff @(posedge clk) begin
		if (!resetn) begin
			level_ff <= 1'b0;
		end else if (request_ff || polled_svc) begin
			level_ff <= 1'b1;
		end else if (svc_level_clear) begin
			level_ff <= 1'b0;
		end
	end

	assign svc_level = level_ff;

	// ----------------------------------------------------------------
	// Sense switches and operand buffer
	// ----------------------------------------------------------------
	logic [svc_panel_pkg::WORD_W-1:0] obuf_ff;
	logic [svc_panel_pkg::WORD_W-1:0] acc_ff;
	logic                             acc_we_ff;
	svc_panel_pkg::core_write_t       cw_ff;
	logic                             capture;

	// Low-true gate is modelled as an AND inverted twice: switch on drives bit high.
	always_comb begin
		chan_bus_out = svc_panel_pkg::WORD_ZERO;
		if (gate_program_switches) begin
			chan_bus_out[svc_panel_pkg::SENSE_W-1:0] = ~(~sense);
		end
	end

	assign capture = execute_io_instruction && t3_data_cycle && (io_cmd != svc_panel_pkg::IO_NONE);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			obuf_ff <= svc_panel_pkg::WORD_ZERO;
		end else if (capture) begin
			obuf_ff <= chan_bus_in;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			acc_ff    <= svc_panel_pkg::WORD_ZERO;
			acc_we_ff <= 1'b0;
		end else begin
			acc_we_ff <= capture && io_cmd == svc_panel_pkg::IO_SENSE_DEVICE;
			if (capture && io_cmd == svc_panel_pkg::IO_SENSE_DEVICE) begin
				acc_ff <= chan_bus_in;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cw_ff <= '0;
		end else begin
			cw_ff.wr <= capture && io_cmd == svc_panel_pkg::IO_READ;
			if (capture && io_cmd == svc_panel_pkg::IO_READ) begin
				cw_ff.addr <= instr_addr;
				cw_ff.data <= chan_bus_in;
			end
		end
	end

	assign operand_buffer   = obuf_ff;
	assign accumulator_load = acc_ff;
	assign accumulator_we   = acc_we_ff;
	assign core_write       = cw_ff;

	// ----------------------------------------------------------------
	// Breaker lamp and use meters
	// ----------------------------------------------------------------
	logic                               lamp_ff;
	logic [svc_panel_pkg::METER_N-1:0]  meter_ff;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			lamp_ff <= 1'b0;
		end else begin
			lamp_ff <= |breaker_trip;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			meter_ff <= '0;
		end else begin
			meter_ff <= customer ? unit_in_use : '0;
		end
	end

	assign breaker_lamp = lamp_ff;
	assign meter_run    = meter_ff;

	// ----------------------------------------------------------------
	// Monitor
	// ----------------------------------------------------------------
	trap_monitor u_monitor (
		.clk       (clk),
		.resetn    (resetn),
		.mode      (mon_mode),
		.lines     (mon_lines),
		.sync      (mon_sync),
		.error     (mon_error),
		.cycle_end (mon_cycle_end),
		.trapped   (mon_trapped),
		.display   (mon_display)
	);
endmodule // service_panel
`default_nettype wire

// file: verif/service_panel_chk.sv
// Checker on the service panel ports.
`default_nettype none
module service_panel_chk (
	input wire logic                       clk,
	input wire logic                       resetn,
	input wire logic                       force_aux_sw,
	input wire logic                       program_load,
	input wire logic                       aux_storage_select,
	input wire logic                       aux_storage_bit,
	input wire logic                       main_storage_inhibit,
	input wire logic [15:0]                svc_vector_addr,
	input wire logic [15:0]                svc_return_addr,
	input wire logic                       execute_io_instruction,
	input wire logic                       t3_data_cycle,
	input wire svc_panel_pkg::io_cmd_t     io_cmd,
	input wire logic [15:0]                instr_addr,
	input wire logic [15:0]                chan_bus_in,
	input wire logic [15:0]                accumulator_load,
	input wire logic                       accumulator_we,
	input wire svc_panel_pkg::core_write_t core_write,
	input wire logic [3:0]                 breaker_trip,
	input wire logic                       breaker_lamp,
	input wire logic                       io_in_service_mode,
	input wire logic [15:0]                polled_io_word,
	input wire logic                       svc_level,
	input wire svc_panel_pkg::disp_mode_t  mon_mode,
	input wire svc_panel_pkg::disp_lines_t mon_lines,
	input wire logic                       mon_sync,
	input wire logic                       mon_trapped,
	input wire svc_panel_pkg::disp_lines_t mon_display
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic cap;
	assign cap = execute_io_instruction && t3_data_cycle;
	AST_AUX_SELECT: assert property ($past(resetn, 2) && $past(resetn) |->
		aux_storage_select == ($past(force_aux_sw, 2) && program_load)) else $error("aux select");
	AST_MAIN_OFF: assert property (main_storage_inhibit == aux_storage_select &&
		(!aux_storage_select || aux_storage_bit)) else $error("main storage not inhibited");
	AST_VECTOR: assert property (svc_vector_addr == 16'h0001 &&
		svc_return_addr == 16'h000a) else $error("vector or return address");
	AST_SENSE_ACC: assert property (cap && io_cmd == svc_panel_pkg::IO_SENSE_DEVICE |=>
		accumulator_we && accumulator_load == $past(chan_bus_in)) else $error("sense load");
	AST_ACC_CAUSE: assert property (accumulator_we |->
		$past(cap) && $past(io_cmd) == svc_panel_pkg::IO_SENSE_DEVICE) else $error("stray load");
	AST_READ_CORE: assert property (cap && io_cmd == svc_panel_pkg::IO_READ |=>
		core_write.wr && core_write.addr == $past(instr_addr) &&
		core_write.data == $past(chan_bus_in)) else $error("core write");
	AST_BREAKER: assert property ($past(resetn) |->
		breaker_lamp == |$past(breaker_trip)) else $error("breaker lamp");
	AST_LEVEL: assert property (io_in_service_mode && polled_io_word[15] |=>
		svc_level) else $error("service level not set");
	AST_CONSOLE: assert property (mon_mode == svc_panel_pkg::DISP_CONSOLE |=>
		mon_display == $past(mon_lines) && !mon_trapped) else $error("console display");
	AST_TRAP_HOLD: assert property (mon_trapped &&
		mon_mode != svc_panel_pkg::DISP_CONSOLE |=> mon_trapped) else $error("trap lost");
	AST_HELD: assert property (mon_trapped && mon_mode == svc_panel_pkg::DISP_SAMPLED &&
		!mon_sync |=> $stable(mon_display)) else $error("trapped display changed");
	AST_SAMPLE: assert property (mon_mode == svc_panel_pkg::DISP_SAMPLED &&
		$rose(mon_sync) && !mon_trapped |=> (mon_display & $past(mon_lines)) == $past(mon_lines))
		else $error("sample not latched");
endmodule // service_panel_chk
bind service_panel service_panel_chk service_panel_chk_i (
	.clk, .resetn, .force_aux_sw, .program_load, .aux_storage_select, .aux_storage_bit,
	.main_storage_inhibit, .svc_vector_addr, .svc_return_addr, .execute_io_instruction,
	.t3_data_cycle, .io_cmd, .instr_addr, .chan_bus_in, .accumulator_load, .accumulator_we,
	.core_write, .breaker_trip, .breaker_lamp, .io_in_service_mode, .polled_io_word,
	.svc_level, .mon_mode, .mon_lines, .mon_sync, .mon_trapped, .mon_display
);
`default_nettype wire

// file: verif/proc_side_model.sv
// Processor-side model: channel data bus, accumulator and a small core store.
`default_nettype none
module proc_side_model (
	input  wire logic                       clk,
	input  wire logic                       gate_program_switches,
	input  wire logic [15:0]                chan_bus_out,
	input  wire logic                       accumulator_we,
	input  wire logic [15:0]                accumulator_load,
	input  wire svc_panel_pkg::core_write_t core_write,
	output logic [15:0]                     chan_bus_in,
	output logic [15:0]                     acc_seen,
	output logic [15:0]                     mem_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] acc_ff = '0;
	logic [15:0] last_ff = '0;
	logic [15:0] mem_ff [16];
	// An ungated bus shows the inverse of its last value, so stale data cannot pass.
	assign chan_bus_in = gate_program_switches ? chan_bus_out : ~last_ff;
	assign acc_seen = acc_ff;
	assign mem_seen = mem_ff[5];
	always_ff @(posedge clk) begin
		if (gate_program_switches)
			last_ff <= chan_bus_out;
		if (accumulator_we)
			acc_ff <= accumulator_load;
		if (core_write.wr)
			mem_ff[core_write.addr[3:0]] <= core_write.data;
	end
endmodule // proc_side_model
`default_nettype wire

// file: verif/service_panel_test.sv
// Self-checking bench for the service panel.
`default_nettype none
module service_panel_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam svc_panel_pkg::disp_lines_t P = 46'h2a5a5a5a5a5a;
	logic clk = 1'h0, resetn = 1'h0, force_aux_sw = 1'h0, int_to_aux_sw = 1'h0;
	logic svc_button = 1'h0, key_customer = 1'h0, program_load = 1'h0, end_op_t7 = 1'h0;
	logic svc_int_taken = 1'h0, svc_level_clear = 1'h0, io_in_service_mode = 1'h0;
	logic gate_program_switches = 1'h0, execute_io_instruction = 1'h0, t3_data_cycle = 1'h0;
	logic mon_sync = 1'h0, mon_error = 1'h0, mon_cycle_end = 1'h0;
	logic [7:0] sense_sw = 8'h00, unit_in_use = 8'h00, meter_run;
	logic [3:0] breaker_trip = 4'h0;
	logic [15:0] polled_io_word = 16'h0000, instr_addr = 16'h0000, chan_bus_in, chan_bus_out;
	logic [15:0] svc_vector_addr, svc_return_addr, operand_buffer, accumulator_load;
	logic [15:0] acc_seen, mem_seen;
	logic aux_storage_select, aux_storage_bit, main_storage_inhibit, svc_level;
	logic accumulator_we, breaker_lamp, mon_trapped;
	svc_panel_pkg::io_cmd_t io_cmd = svc_panel_pkg::IO_NONE;
	svc_panel_pkg::disp_mode_t mon_mode = svc_panel_pkg::DISP_CONSOLE;
	svc_panel_pkg::disp_lines_t mon_lines = '0, mon_display;
	svc_panel_pkg::core_write_t core_write;
	int n_errors = 0, cmp_count = 0;
	always #50 clk = ~clk;
	service_panel service_panel_i (
		.clk, .resetn, .force_aux_sw, .int_to_aux_sw, .svc_button, .sense_sw, .key_customer,
		.breaker_trip, .unit_in_use, .program_load, .end_op_t7, .svc_int_taken,
		.svc_level_clear, .polled_io_word, .io_in_service_mode, .gate_program_switches,
		.execute_io_instruction, .io_cmd, .t3_data_cycle, .instr_addr, .chan_bus_in,
		.chan_bus_out, .aux_storage_select, .aux_storage_bit, .main_storage_inhibit,
		.svc_level, .svc_vector_addr, .svc_return_addr, .operand_buffer, .accumulator_load,
		.accumulator_we, .core_write, .breaker_lamp, .meter_run, .mon_mode, .mon_lines,
		.mon_sync, .mon_error, .mon_cycle_end, .mon_trapped, .mon_display
	);
	proc_side_model proc_side_model_i (.clk, .gate_program_switches, .chan_bus_out,
		.accumulator_we, .accumulator_load, .core_write, .chan_bus_in, .acc_seen, .mem_seen);
	task automatic fail(input string what);
		n_errors++;
		$display("unexpected at %0t: %s differs", $time, what);
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) fail("bit");
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) fail("word");
	endtask
	task automatic cmp_disp(input svc_panel_pkg::disp_lines_t got, exp);
		cmp_count++;
		if (got !== exp) fail("display");
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic look;
		@(negedge clk);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic clear_svc;
		@(posedge clk);
		svc_int_taken <= 1'h1;
		@(posedge clk);
		svc_int_taken <= 1'h0;
		svc_level_clear <= 1'h1;
		@(posedge clk);
		svc_level_clear <= 1'h0;
	endtask
	task automatic t7_pulse;
		@(posedge clk);
		end_op_t7 <= 1'h1;
		@(posedge clk);
		end_op_t7 <= 1'h0;
		look;
	endtask
	task automatic t_force;
		@(posedge clk);
		force_aux_sw <= 1'h1;
		program_load <= 1'h1;
		step(3);
		look;
		cmp_bit(aux_storage_select, 1'h1);
		cmp_bit(main_storage_inhibit, 1'h1);
		@(posedge clk);
		program_load <= 1'h0;
		look;
		cmp_bit(main_storage_inhibit, 1'h0);
		@(posedge clk);
		force_aux_sw <= 1'h0;
		done("force");
	endtask
	task automatic t_service;
		@(posedge clk);
		int_to_aux_sw <= 1'h1;
		svc_button <= 1'h1;
		step(6);
		look;
		cmp_bit(svc_level, 1'h1);
		cmp_bit(aux_storage_bit, 1'h0);
		t7_pulse;
		cmp_bit(aux_storage_bit, 1'h1);
		cmp_word(svc_vector_addr, 16'h0001);
		cmp_word(svc_return_addr, 16'h000a);
		clear_svc;
		t7_pulse;
		cmp_bit(aux_storage_bit, 1'h0);
		step(6);
		look;
		cmp_bit(svc_level, 1'h0);
		@(posedge clk);
		svc_button <= 1'h0;
		int_to_aux_sw <= 1'h0;
		step(4);
		svc_button <= 1'h1;
		step(6);
		look;
		cmp_bit(svc_level, 1'h1);
		t7_pulse;
		cmp_bit(aux_storage_bit, 1'h0);
		clear_svc;
		svc_button <= 1'h0;
		done("service");
	endtask
	task automatic t_polled;
		@(posedge clk);
		polled_io_word <= 16'h8000;
		step(2);
		look;
		cmp_bit(svc_level, 1'h0);
		@(posedge clk);
		io_in_service_mode <= 1'h1;
		@(posedge clk);
		io_in_service_mode <= 1'h0;
		look;
		cmp_bit(svc_level, 1'h1);
		clear_svc;
		polled_io_word <= 16'h7fff;
		io_in_service_mode <= 1'h1;
		step(2);
		look;
		cmp_bit(svc_level, 1'h0);
		@(posedge clk);
		io_in_service_mode <= 1'h0;
		done("polled");
	endtask
	task automatic t_io;
		@(posedge clk);
		sense_sw <= 8'ha5;
		instr_addr <= 16'h0005;
		step(3);
		look;
		cmp_word(chan_bus_out, 16'h0000);
		@(posedge clk);
		gate_program_switches <= 1'h1;
		look;
		cmp_word(chan_bus_out, 16'h00a5);
		@(posedge clk);
		execute_io_instruction <= 1'h1;
		t3_data_cycle <= 1'h1;
		io_cmd <= svc_panel_pkg::IO_SENSE_DEVICE;
		@(posedge clk);
		io_cmd <= svc_panel_pkg::IO_READ;
		sense_sw <= 8'h3c;
		@(posedge clk);
		execute_io_instruction <= 1'h0;
		t3_data_cycle <= 1'h0;
		io_cmd <= svc_panel_pkg::IO_NONE;
		step(2);
		look;
		cmp_word(operand_buffer, 16'h00a5);
		cmp_word(acc_seen, 16'h00a5);
		cmp_word(mem_seen, 16'h00a5);
		@(posedge clk);
		execute_io_instruction <= 1'h1;
		io_cmd <= svc_panel_pkg::IO_SENSE_DEVICE;
		@(posedge clk);
		execute_io_instruction <= 1'h0;
		gate_program_switches <= 1'h0;
		look;
		cmp_word(operand_buffer, 16'h00a5);
		done("io");
	endtask
	task automatic t_lamp_meter;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			breaker_trip <= 4'h1 << i;
			@(posedge clk);
			look;
			cmp_bit(breaker_lamp, 1'h1);
		end
		@(posedge clk);
		breaker_trip <= 4'h0;
		key_customer <= 1'h1;
		unit_in_use <= 8'h5a;
		step(5);
		look;
		cmp_bit(breaker_lamp, 1'h0);
		cmp_word({8'h00, meter_run}, 16'h005a);
		@(posedge clk);
		key_customer <= 1'h0;
		step(5);
		look;
		cmp_word({8'h00, meter_run}, 16'h0000);
		done("lamp and meter");
	endtask
	task automatic t_monitor;
		@(posedge clk);
		mon_lines <= P;
		@(posedge clk);
		mon_lines <= '0;
		look;
		cmp_disp(mon_display, P);
		@(posedge clk);
		mon_mode <= svc_panel_pkg::DISP_SAMPLED;
		@(posedge clk);
		mon_lines <= P;
		mon_sync <= 1'h1;
		@(posedge clk);
		mon_lines <= ~P;
		@(posedge clk);
		mon_sync <= 1'h0;
		mon_error <= 1'h1;
		look;
		cmp_disp(mon_display, P);
		@(posedge clk);
		mon_error <= 1'h0;
		mon_cycle_end <= 1'h1;
		@(posedge clk);
		mon_cycle_end <= 1'h0;
		step(1);
		look;
		cmp_bit(mon_trapped, 1'h1);
		cmp_disp(mon_display, P);
		@(posedge clk);
		mon_mode <= svc_panel_pkg::DISP_CONSOLE;
		mon_lines <= '0;
		step(2);
		look;
		cmp_bit(mon_trapped, 1'h0);
		@(posedge clk);
		mon_mode <= svc_panel_pkg::DISP_GATED;
		@(posedge clk);
		mon_lines <= 46'h00000000f0f;
		mon_sync <= 1'h1;
		@(posedge clk);
		mon_lines <= 46'h30000000000;
		@(posedge clk);
		mon_sync <= 1'h0;
		mon_lines <= '0;
		look;
		cmp_disp(mon_display, 46'h30000000f0f);
		@(posedge clk);
		mon_cycle_end <= 1'h1;
		@(posedge clk);
		mon_cycle_end <= 1'h0;
		step(1);
		look;
		cmp_disp(mon_display, '0);
		done("monitor");
	endtask
	task automatic report_and_stop;
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		step(4);
		resetn <= 1'h1;
		t_force;
		t_service;
		t_polled;
		t_io;
		t_lamp_meter;
		t_monitor;
		report_and_stop;
	end
	// The tests need about 110 cycles; this cuts a hang short.
	initial begin
		step(3000);
		n_errors++;
		report_and_stop;
	end
endmodule // service_panel_test
`default_nettype wire
